// File: acdec_pkg.sv
/*
 * shared constants, state codes and the select decode function for the
 * bus address decoder.
 * assumes a 16-bit address, 8-bit data processor bus sampled on clk.
 */
package acdec_pkg;

   localparam int ADDR_W   = 16;
   localparam int DATA_W   = 8;
   localparam int BLK_W    = 3;
   localparam int NUM_SEL  = 8;
   localparam int BLK_AW   = 13;
   localparam int PROG_AW  = 16;

   // block numbers of the 8k-byte data windows
   localparam logic [2:0] BLK_EEPROM = 3'h0;
   localparam logic [2:0] BLK_RAM    = 3'h1;
   localparam logic [2:0] BLK_DSP    = 3'h2;
   localparam logic [2:0] BLK_IO     = 3'h3;
   localparam logic [2:0] BLK_TIMER  = 3'h4;
   localparam logic [2:0] BLK_PPI    = 3'h5;
   localparam logic [2:0] BLK_SPARE0 = 3'h6;
   localparam logic [2:0] BLK_SPARE1 = 3'h7;

   localparam logic [7:0] SEL_IDLE  = 8'hff;
   localparam logic [7:0] USED_MASK = 8'h3f;
   localparam logic [7:0] AD_RESET  = 8'h00;
   localparam logic [15:0] ADDR_RESET = 16'h0000;

   typedef enum logic [4:0]
   {
      PH_IDLE  = 5'h01,
      PH_ADDR  = 5'h02,
      PH_FETCH = 5'h04,
      PH_READ  = 5'h08,
      PH_WRITE = 5'h10
   } acdec_phase_type;

   // active-low one-of-eight select, all high during program fetch
   function automatic logic [7:0] acdec_sel_decode
   (
      input logic [2:0] blk,
      input logic       program_store_strobe_n
   );
      logic [7:0] sel;
      sel = SEL_IDLE;
      if (program_store_strobe_n && USED_MASK[blk])
      begin
         sel[blk] = 1'b0;
      end
      return sel;
   endfunction

endpackage

// File: acdec_mem_if.sv
/*
 * port bundle between the decoder top and one byte-wide memory array.
 * assumes a single clock; read data is combinational from the address.
 */
`timescale 1ns/100ps
interface acdec_mem_if
#(
   parameter int AW = 13,
   parameter int DW = 8
);
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic          we;
   logic [DW-1:0] rdata;

   modport user
   (
      output addr,
      output wdata,
      output we,
      input  rdata
   );

   modport mem
   (
      input  addr,
      input  wdata,
      input  we,
      output rdata
   );
endinterface

// File: acdec_mem.sv
/*
 * byte-wide storage array with one write port and asynchronous read.
 * assumes the user side holds we for one clock per stored byte.
 */
`timescale 1ns/100ps
module acdec_mem
#(
   parameter int AW = 13,
   parameter int DW = 8
)
(
   input wire logic clk,
   acdec_mem_if.mem port
);
   logic [DW-1:0] store [2**AW];

   always_ff @(posedge clk)
   begin
      if (port.we)
      begin
         store[port.addr] <= port.wdata;
      end
   end

   assign port.rdata = store[port.addr];
endmodule

// File: acdec_decode.sv
/*
 * address latch and select decode.
 * assumes ale, ad_in and addr_hi are synchronous to clk.
 */
`timescale 1ns/100ps
module acdec_decode
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ale,
   input  wire logic [7:0]  ad_in,
   input  wire logic [7:0]  addr_hi,
   input  wire logic        program_store_strobe_n,
   output logic      [15:0] lat_addr,
   output logic      [7:0]  next_sel_n
);
   logic       ale_q;
   logic [7:0] addr_lo;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ale_q   <= 1'b0;
         addr_lo <= acdec_pkg::AD_RESET;
      end
      else
      begin
         ale_q <= ale;
         if (ale && !ale_q)
         begin
            addr_lo <= ad_in;
         end
      end
   end

   assign lat_addr   = {addr_hi, addr_lo};
   assign next_sel_n = acdec_pkg::acdec_sel_decode(lat_addr[15:13],
                          program_store_strobe_n);
endmodule

// File: acdec_top.sv
/*
 * bus glue for a processor with a multiplexed address/data bus: address
 * latch, data-space select decode, program store, static ram and eeprom.
 * assumes all pins are synchronous to clk; resetn is the board reset.
 */
`timescale 1ns/100ps

// How it works
// - the low address byte is caught on the rise of ale and held.
// - the high address byte passes straight through without a latch.
// - the top three address bits pick one of eight 8k-byte blocks, six of which have a select.
// - while the program-store strobe is low every select stays high.
// - block 0 is eeprom, block 1 is ram, block 2 is the dsp port.
// - block 3 is io, 4 the timer, 5 the ppi, blocks 6 and 7 select nothing.
// - program and data are two separate 64k-byte spaces.
// - a fetch drives the program byte at the full address onto ad.
// - with its select and read strobe low the ram drives its byte.
// - with its select and write strobe low the ram stores the ad byte.
// - with chip enable and read strobe low the eeprom drives its byte.
// - with chip enable and write strobe low the eeprom stores the byte.
// - the eeprom chip enable stays inactive throughout reset.
module acdec_top
#(
   parameter int PROG_AW = acdec_pkg::PROG_AW,
   parameter int BLK_AW  = acdec_pkg::BLK_AW
)
(
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  ale,
   input  wire logic [7:0]            ad_in,
   input  wire logic [7:0]            addr_hi,
   input  wire logic                  program_store_strobe_n,
   input  wire logic                  rd_n,
   input  wire logic                  wr_n,
   input  wire logic                  prog_load_we,
   input  wire logic [PROG_AW-1:0]    prog_load_addr,
   input  wire logic [7:0]            prog_load_data,
   output logic      [7:0]            ad_out,
   output logic                       ad_oe,
   output logic      [7:0]            sel_n,
   output logic                       eeprom_ce_n,
   output logic                       eeprom_oe_n,
   output logic                       eeprom_we_n,
   output logic                       ram_oe_n,
   output logic                       ram_we_n,
   output acdec_pkg::acdec_phase_type bus_phase
);
   logic [15:0] lat_addr;
   logic [7:0]  next_sel_n;
   logic        wr_q;
   logic        ale_q;
   logic        wr_fall;
   logic        ram_hit;
   logic        eeprom_hit;
   acdec_pkg::acdec_phase_type next_phase;

   acdec_mem_if #(.AW(PROG_AW), .DW(8)) prog_if ();
   acdec_mem_if #(.AW(BLK_AW), .DW(8))  ram_if ();
   acdec_mem_if #(.AW(BLK_AW), .DW(8))  eeprom_if ();

   acdec_decode u_decode
   (
      .clk        (clk),
      .resetn     (resetn),
      .ale        (ale),
      .ad_in      (ad_in),
      .addr_hi    (addr_hi),
      .program_store_strobe_n (program_store_strobe_n),
      .lat_addr   (lat_addr),
      .next_sel_n (next_sel_n)
   );

   acdec_mem #(.AW(PROG_AW), .DW(8)) u_prog
   (
      .clk  (clk),
      .port (prog_if.mem)
   );

   acdec_mem #(.AW(BLK_AW), .DW(8)) u_ram
   (
      .clk  (clk),
      .port (ram_if.mem)
   );

   acdec_mem #(.AW(BLK_AW), .DW(8)) u_eeprom
   (
      .clk  (clk),
      .port (eeprom_if.mem)
   );

   assign ram_hit    = !next_sel_n[acdec_pkg::BLK_RAM];
   assign eeprom_hit = !next_sel_n[acdec_pkg::BLK_EEPROM] && resetn;
   assign wr_fall    = !wr_n && wr_q;

   // program space is reached by the strobe alone, never via a select
   assign prog_if.addr  = prog_load_we ? prog_load_addr
                                       : lat_addr[PROG_AW-1:0];
   assign prog_if.wdata = prog_load_data;
   assign prog_if.we    = prog_load_we;

   assign ram_if.addr    = lat_addr[BLK_AW-1:0];
   assign ram_if.wdata   = ad_in;
   assign ram_if.we      = wr_fall && ram_hit;

   assign eeprom_if.addr  = lat_addr[BLK_AW-1:0];
   assign eeprom_if.wdata = ad_in;
   assign eeprom_if.we    = wr_fall && eeprom_hit;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wr_q  <= 1'b1;
         ale_q <= 1'b0;
      end
      else
      begin
         wr_q  <= wr_n;
         ale_q <= ale;
      end
   end

   // bus cycle tracker, a new ale always restarts the cycle
   always_comb
   begin
      next_phase = bus_phase;
      if (ale && !ale_q)
      begin
         next_phase = acdec_pkg::PH_ADDR;
      end
      else
      begin
         case (bus_phase)
            acdec_pkg::PH_IDLE:
            begin
               next_phase = acdec_pkg::PH_IDLE;
            end
            acdec_pkg::PH_ADDR:
            begin
               if (!program_store_strobe_n)
                  next_phase = acdec_pkg::PH_FETCH;
               else if (!rd_n)
                  next_phase = acdec_pkg::PH_READ;
               else if (!wr_n)
                  next_phase = acdec_pkg::PH_WRITE;
            end
            acdec_pkg::PH_FETCH:
            begin
               if (program_store_strobe_n)
                  next_phase = acdec_pkg::PH_IDLE;
            end
            acdec_pkg::PH_READ:
            begin
               if (rd_n)
                  next_phase = acdec_pkg::PH_IDLE;
            end
            acdec_pkg::PH_WRITE:
            begin
               if (wr_n)
                  next_phase = acdec_pkg::PH_IDLE;
            end
            default:
            begin
               next_phase = acdec_pkg::PH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         bus_phase <= acdec_pkg::PH_IDLE;
      else
         bus_phase <= next_phase;
   end

   // external selects
   always_ff @(posedge clk)
   begin
      if (!resetn)
         sel_n <= acdec_pkg::SEL_IDLE;
      else
         sel_n <= next_sel_n;
   end

   // memory strobes
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         eeprom_ce_n <= 1'b1;
         eeprom_oe_n <= 1'b1;
         eeprom_we_n <= 1'b1;
         ram_oe_n    <= 1'b1;
         ram_we_n    <= 1'b1;
      end
      else
      begin
         eeprom_ce_n <= !eeprom_hit;
         eeprom_oe_n <= rd_n || !eeprom_hit;
         eeprom_we_n <= wr_n || !eeprom_hit;
         ram_oe_n    <= rd_n || !ram_hit;
         ram_we_n    <= wr_n || !ram_hit;
      end
   end

   // data return onto the shared ad lines, fetch has priority
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ad_out <= acdec_pkg::AD_RESET;
         ad_oe  <= 1'b0;
      end
      else if (!program_store_strobe_n)
      begin
         ad_out <= prog_if.rdata;
         ad_oe  <= 1'b1;
      end
      else if (!rd_n && ram_hit)
      begin
         ad_out <= ram_if.rdata;
         ad_oe  <= 1'b1;
      end
      else if (!rd_n && eeprom_hit)
      begin
         ad_out <= eeprom_if.rdata;
         ad_oe  <= 1'b1;
      end
      else
      begin
         ad_out <= acdec_pkg::AD_RESET;
         ad_oe  <= 1'b0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_latch_capture: assert property (ale && !ale_q |=>
      lat_addr[7:0] == $past(ad_in))
      else $error("low address byte not caught on ale rise");

   a_latch_hold: assert property (!ale |=>
      $stable(lat_addr[7:0]))
      else $error("low address byte changed without ale");

   a_high_direct: assert property (lat_addr[15:8] == addr_hi)
      else $error("high address byte not passed straight through");

   a_one_select: assert property (program_store_strobe_n |=>
      $countones(~sel_n) <= 1 &&
      sel_n == (($past(lat_addr[15:13]) < 3'h6) ?
                ~(8'h01 << $past(lat_addr[15:13])) : 8'hff))
      else $error("select does not match the address block");

   a_fetch_blocks: assert property (!program_store_strobe_n |=>
      sel_n == acdec_pkg::SEL_IDLE)
      else $error("select active during program fetch");

   a_low_map: assert property (program_store_strobe_n &&
      lat_addr[15:13] == acdec_pkg::BLK_RAM |=> sel_n == 8'hfd)
      else $error("ram block does not select the ram");

   a_spare_idle: assert property (sel_n[7:6] == 2'h3)
      else $error("spare block produced a select");

   a_fetch_drive: assert property (!program_store_strobe_n |=>
      ad_oe && ad_out == $past(prog_if.rdata))
      else $error("fetch byte not driven on ad");

   a_ram_read: assert property (program_store_strobe_n && !rd_n &&
      ram_hit |=> ad_oe && !ram_oe_n && ad_out == $past(ram_if.rdata))
      else $error("ram read byte not driven on ad");

   a_ram_write: assert property (ram_if.we |-> !wr_n &&
      lat_addr[15:13] == acdec_pkg::BLK_RAM ##1 !ram_we_n)
      else $error("ram stored without select and write strobe");

   a_eeprom_read: assert property (program_store_strobe_n && !rd_n &&
      eeprom_hit |=> ad_oe && !eeprom_oe_n && !eeprom_ce_n)
      else $error("eeprom read not driven");

   a_eeprom_write: assert property (eeprom_if.we |-> !wr_n &&
      lat_addr[15:13] == acdec_pkg::BLK_EEPROM ##1 !eeprom_we_n)
      else $error("eeprom stored without enable and write strobe");

   a_eeprom_reset: assert property (@(posedge clk) disable iff (1'b0)
      !resetn |=> eeprom_ce_n && eeprom_we_n)
      else $error("eeprom enabled during reset");

   a_strobe_gate: assert property (!program_store_strobe_n |->
      (!ram_if.we && !eeprom_if.we) ##1 (ram_oe_n && eeprom_ce_n))
      else $error("data space reached during fetch");

   a_two_spaces: assert property (!program_store_strobe_n |=>
      ad_out == $past(prog_if.rdata) && ram_oe_n && eeprom_oe_n)
      else $error("data space answered a program fetch");

endmodule

// File: acdec_cpu_model.sv
/*
 * processor side of the bus: one read, write or fetch cycle per call.
 * assumes the decoder samples every input on the rising edge of clk.
 */
`timescale 1ns/100ps
module acdec_cpu_model
(
   input  wire logic       clk,
   output logic            ale,
   output logic [7:0]      ad_in,
   output logic [7:0]      addr_hi,
   output logic            program_store_strobe_n,
   output logic            rd_n,
   output logic            wr_n,
   input  wire logic [7:0] ad_out,
   input  wire logic       ad_oe,
   input  wire logic [7:0] sel_n,
   input  wire logic [4:0] ctl_n,
   input  wire logic [4:0] phase
);
   logic [7:0] snap_ad;
   logic [7:0] snap_sel;
   logic       snap_oe;
   logic [4:0] snap_ctl;
   logic [4:0] snap_ph;

   initial
   begin
      ale = 1'b0;
      ad_in = 8'h00;
      addr_hi = 8'h00;
      program_store_strobe_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
   end

   // kind 0 fetch, 1 read, 2 write
   task automatic cycle(input int kind, input logic [15:0] a,
                        input logic [7:0] wd);
      @(posedge clk) #1;
      ale = 1'b1;
      ad_in = a[7:0];
      addr_hi = a[15:8];
      @(posedge clk) #1;
      ale = 1'b0;
      ad_in = ~a[7:0];
      @(posedge clk) #1;
      ad_in = (kind == 2) ? wd : ~ad_in;
      program_store_strobe_n = (kind != 0);
      rd_n = (kind != 1);
      wr_n = (kind != 2);
      @(posedge clk) #1;
      snap_ad = ad_out;
      snap_oe = ad_oe;
      snap_sel = sel_n;
      snap_ctl = ctl_n;
      snap_ph = phase;
      program_store_strobe_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      ad_in = ~ad_in;
   endtask
endmodule

// File: tb_cpu_bus_address_decode.sv
/*
 * self-checking bench for the bus decoder top.
 * assumes acdec_cpu_model plays the processor on the bus pins.
 */
`timescale 1ns/100ps
module tb_cpu_bus_address_decode;
   logic                       clk = 1'b0;
   logic                       resetn = 1'b0;
   logic                       prog_load_we = 1'b0;
   logic [15:0]                prog_load_addr = 16'h0000;
   logic [7:0]                 prog_load_data = 8'h00;
   logic                       ale;
   logic                       program_store_strobe_n;
   logic                       rd_n;
   logic                       wr_n;
   logic [7:0]                 ad_in;
   logic [7:0]                 addr_hi;
   logic [7:0]                 ad_out;
   logic                       ad_oe;
   logic [7:0]                 sel_n;
   logic                       ee_ce_n;
   logic                       ee_oe_n;
   logic                       ee_we_n;
   logic                       ram_oe_n;
   logic                       ram_we_n;
   acdec_pkg::acdec_phase_type bus_phase;
   int                         failures = 0;
   int                         compares = 0;

   always #10 clk = ~clk;

   acdec_top DUT
   (
      .clk(clk), .resetn(resetn), .ale(ale), .ad_in(ad_in),
      .addr_hi(addr_hi),
      .program_store_strobe_n(program_store_strobe_n),
      .rd_n(rd_n), .wr_n(wr_n), .prog_load_we(prog_load_we),
      .prog_load_addr(prog_load_addr), .prog_load_data(prog_load_data),
      .ad_out(ad_out), .ad_oe(ad_oe), .sel_n(sel_n),
      .eeprom_ce_n(ee_ce_n), .eeprom_oe_n(ee_oe_n),
      .eeprom_we_n(ee_we_n), .ram_oe_n(ram_oe_n),
      .ram_we_n(ram_we_n), .bus_phase(bus_phase)
   );

   acdec_cpu_model cpu
   (
      .clk(clk), .ale(ale), .ad_in(ad_in), .addr_hi(addr_hi),
      .program_store_strobe_n(program_store_strobe_n),
      .rd_n(rd_n), .wr_n(wr_n),
      .ad_out(ad_out), .ad_oe(ad_oe), .sel_n(sel_n),
      .ctl_n({ee_ce_n, ee_oe_n, ee_we_n, ram_oe_n, ram_we_n}),
      .phase(bus_phase)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string msg);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   task automatic print_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // control strobes expected for a data access to block b
   function automatic logic [4:0] ctl_exp(input logic [2:0] b, input int k);
      return {b != 3'h0, !(b == 3'h0 && k == 1), !(b == 3'h0 && k == 2),
              !(b == 3'h1 && k == 1), !(b == 3'h1 && k == 2)};
   endfunction

   task automatic test_reset();
      repeat (2) @(posedge clk);
      cpu.cycle(2, 16'h0010, 8'h99);
      check(cpu.snap_ctl, 16'h001f, "eeprom enabled in reset");
      check(cpu.snap_sel, 16'h00ff, "select low in reset");
      check(cpu.snap_oe, 16'h0000, "bus driven in reset");
      repeat (14) @(posedge clk);
      #1 resetn = 1'b1;
      $display("reset test done");
   endtask

   task automatic test_decode();
      logic [15:0] a;
      logic [7:0]  exp_sel;
      for (int b = 0; b < 8; b++)
      begin
         a = {b[2:0], (b % 2) ? 13'h1fff : 13'h0000};
         cpu.cycle(1, a, 8'h00);
         exp_sel = (b < 6) ? 8'(~(8'h01 << b)) : 8'hff;
         check(cpu.snap_sel, exp_sel, "select");
         check(cpu.snap_ctl, ctl_exp(b[2:0], 1), "read strobes");
         check(cpu.snap_ph, acdec_pkg::PH_READ, "read phase");
      end
      $display("decode test done");
   endtask

   task automatic test_memory();
      logic [15:0] wa [4] = '{16'h2345, 16'h0345, 16'h6345, 16'h3fff};
      logic [7:0]  wd [4] = '{8'ha5, 8'hc3, 8'hff, 8'h5a};
      for (int i = 0; i < 4; i++)
      begin
         cpu.cycle(2, wa[i], wd[i]);
         check(cpu.snap_ctl, ctl_exp(wa[i][15:13], 2), "write");
         check(cpu.snap_ph, acdec_pkg::PH_WRITE, "write phase");
      end
      for (int i = 0; i < 4; i++)
      begin
         if (i != 2)
         begin
            cpu.cycle(1, wa[i], 8'h00);
            check(cpu.snap_ad, wd[i], "stored");
            check(cpu.snap_oe, 16'h0001, "read not driven");
         end
      end
      $display("memory test done");
   endtask

   task automatic test_fetch();
      @(posedge clk) #1;
      prog_load_we = 1'b1;
      prog_load_addr = 16'he345;
      prog_load_data = 8'h3c;
      @(posedge clk) #1;
      prog_load_addr = 16'h2345;
      prog_load_data = 8'h77;
      @(posedge clk) #1;
      prog_load_we = 1'b0;
      cpu.cycle(0, 16'he345, 8'h00);
      check(cpu.snap_ad, 16'h003c, "fetch byte");
      cpu.cycle(0, 16'h2345, 8'h00);
      check(cpu.snap_ad, 16'h0077, "fetch uses program space");
      check(cpu.snap_oe, 16'h0001, "fetch not driven");
      check(cpu.snap_sel, 16'h00ff, "select during fetch");
      check(cpu.snap_ctl, 16'h001f, "data strobe during fetch");
      check(cpu.snap_ph, acdec_pkg::PH_FETCH, "fetch phase");
      cpu.cycle(1, 16'h2345, 8'h00);
      check(cpu.snap_ad, 16'h00a5, "data space disturbed");
      $display("fetch test done");
   endtask

   initial
   begin
      repeat (3000) @(posedge clk);
      failures++;
      $display("wrong value at %0t: run timed out", $time);
      print_verdict();
   end

   initial
   begin
      test_reset();
      test_decode();
      test_memory();
      test_fetch();
      print_verdict();
   end
endmodule
